// *** logic/sfeac_pkg.sv ***
// Shared constants and types for the sampling filter and equalizer adaption control
package sfeac_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_FILTER_CONTROL = 8'h40;
  localparam logic [7:0] ADDR_FILTER_LIMITS  = 8'h41;
  localparam logic [7:0] ADDR_EQ_CONTROL     = 8'h42;
  localparam logic [7:0] ADDR_EQ_THRESHOLD   = 8'h43;

  // sampling_filter_control fields
  localparam int FC_ALWAYS_BIT  = 7;
  localparam int FC_TIMING_BIT  = 1;
  localparam int FC_DYNAMIC_BIT = 0;
  localparam logic [7:0] FC_RESET = 8'h00;

  // sampling_filter_limits fields
  localparam int FL_UPPER_LSB = 4;
  localparam int FL_LOWER_LSB = 0;
  localparam logic [7:0] FL_RESET = 8'h86;

  // equalizer_control fields
  localparam int EC_RESERVED_BIT = 7;
  localparam int EC_ERRSEL_LSB   = 4;
  localparam int EC_ORDER_BIT    = 3;
  localparam int EC_TWOSTEP_BIT  = 2;
  localparam logic [7:0] EC_RESET   = 8'h74;
  localparam logic [7:0] EC_RW_MASK = 8'h7F;

  // equalizer_error_threshold
  localparam logic [7:0] THRESHOLD_RESET = 8'h01;

  // Filter setting range
  localparam logic [3:0] FILTER_MIDPOINT = 4'h7;
  localparam logic [3:0] FILTER_MAXIMUM  = 4'hE;

  // Link error strobes, one cycle each
  typedef struct packed {
    logic clockBit;
    logic controlSequence;
    logic parity;
  } sfeac_err_s;

  // Validation outcome of one equalizer trial
  typedef struct packed {
    logic pass;
    logic fail;
  } sfeac_verdict_s;

  typedef enum logic [1:0] {
    VAL_IDLE,
    VAL_WAIT,
    VAL_CHECK
  } sfeac_val_e;

endpackage

// *** logic/sfeac_ctrl.sv ***
// Sampling filter and adaptive equalizer adaption control with its register set

// Functional notes
// - Timing bit 0: adapt filter after frequency lock; 1: after equalizer adaption done.
// - Dynamic filter delay adaption only while dynamic enable bit set; resets to 0.
// - Upper limit field bits 7:4, reset 0x8; settings 0 to 14, centre 7.
// - Lower limit field bits 3:0, reset 0x6; setting never goes below it unless the upper limit, capped at 14, is below it.
// - Same limits apply to equalizer-driven and dynamic filter adaption.
// - Error select field bits 6:4, reset 0x7; any bit enables error checking.
// - Select bit 2 clock-bit, bit 1 sequence, bit 0 parity errors.
// - Selected errors accumulate over half the relock period before threshold compare.
// - Count above threshold requests an equalizer step upward.
// - Two-step validation uses the selected errors to validate each trial setting.
// - Order bit 0 starts at largest clock delay; 1 starts at midpoint.
// - Equalizer control bit 7 is reserved, read-only, reads zero.
// - Always-on bit allows filter adaption anytime, overriding the timing bit.
// - Two-step: wait half period, check remaining half, fail at once on error.
module sfeac_ctrl #(
  parameter int RELOCK_CYCLES = 8192
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  // Register access
  input  wire logic [7:0]            regAddr,
  input  wire logic                  regWrite,
  input  wire logic [7:0]            regWdata,
  input  wire logic                  regRead,
  output logic      [7:0]            regRdata,
  // Link status
  input  wire logic                  freqLock,
  input  wire logic                  eqAdaptDone,
  input  wire logic                  eqAdaptActive,
  input  wire sfeac_pkg::sfeac_err_s linkErr,
  // Filter adaption requests from the phase measurement
  input  wire logic                  filterIncrement,
  input  wire logic                  filterDecrement,
  // Equalizer sweep and trial control
  input  wire logic                  eqSweepStart,
  input  wire logic                  eqTrialStart,
  // Results
  output logic      [3:0]            filterSetting,
  output logic                       filterAdaptActive,
  output logic                       eqStepUp,
  output sfeac_pkg::sfeac_verdict_s  trialVerdict
);

  localparam int HALF_CYCLES = (RELOCK_CYCLES / 2 < 1) ? 1 : RELOCK_CYCLES / 2;
  localparam int CNT_W       = $clog2(HALF_CYCLES + 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYCLES - 1);

  logic [7:0] filterControl;
  logic [7:0] filterLimits;
  logic [7:0] eqControl;
  logic [7:0] errThreshold;

  // Register decode
  wire wrFilterControl = regWrite && (regAddr == sfeac_pkg::ADDR_FILTER_CONTROL);
  wire wrFilterLimits  = regWrite && (regAddr == sfeac_pkg::ADDR_FILTER_LIMITS);
  wire wrEqControl     = regWrite && (regAddr == sfeac_pkg::ADDR_EQ_CONTROL);
  wire wrThreshold     = regWrite && (regAddr == sfeac_pkg::ADDR_EQ_THRESHOLD);

  always_ff @(posedge clock) begin
    if (rst) begin
      filterControl <= sfeac_pkg::FC_RESET;
      filterLimits  <= sfeac_pkg::FL_RESET;
      eqControl     <= sfeac_pkg::EC_RESET;
      errThreshold  <= sfeac_pkg::THRESHOLD_RESET;
    end else begin
      if (wrFilterControl) filterControl <= regWdata;
      if (wrFilterLimits)  filterLimits  <= regWdata;
      if (wrEqControl)     eqControl     <= regWdata & sfeac_pkg::EC_RW_MASK;
      if (wrThreshold)     errThreshold  <= regWdata;
    end
  end

  // Read path: unmapped offsets read as zero
  logic [7:0] readMux;
  always_comb begin
    case (regAddr)
      sfeac_pkg::ADDR_FILTER_CONTROL: readMux = filterControl;
      sfeac_pkg::ADDR_FILTER_LIMITS:  readMux = filterLimits;
      sfeac_pkg::ADDR_EQ_CONTROL:     readMux = eqControl;
      sfeac_pkg::ADDR_EQ_THRESHOLD:   readMux = errThreshold;
      default:                        readMux = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) regRdata <= 8'h00;
    else if (regRead) regRdata <= readMux;
  end

  // Field views
  wire       adaptAlways  = filterControl[sfeac_pkg::FC_ALWAYS_BIT];
  wire       adaptTiming  = filterControl[sfeac_pkg::FC_TIMING_BIT];
  wire       dynamicEn    = filterControl[sfeac_pkg::FC_DYNAMIC_BIT];
  wire [3:0] upperLimit   = filterLimits[sfeac_pkg::FL_UPPER_LSB +: 4];
  wire [3:0] lowerLimit   = filterLimits[sfeac_pkg::FL_LOWER_LSB +: 4];
  wire [2:0] errSelect    = eqControl[sfeac_pkg::EC_ERRSEL_LSB +: 3];
  wire       midpointStart = eqControl[sfeac_pkg::EC_ORDER_BIT];
  wire       twoStepEn    = eqControl[sfeac_pkg::EC_TWOSTEP_BIT];

  // An upper limit above the legal range is treated as the top legal setting
  function automatic logic [3:0] clampSetting(input logic [3:0] value,
                                              input logic [3:0] lower,
                                              input logic [3:0] upper);
    logic [3:0] top;
    top = (upper > sfeac_pkg::FILTER_MAXIMUM) ? sfeac_pkg::FILTER_MAXIMUM : upper;
    if (value > top)        clampSetting = top;
    else if (value < lower) clampSetting = lower;
    else                    clampSetting = value;
  endfunction

  // Adaption gating
  wire adaptStartCond = adaptTiming ? eqAdaptDone : freqLock;
  wire adaptAllowed   = adaptAlways || adaptStartCond;
  wire dynamicGo      = dynamicEn && adaptAllowed;

  always_ff @(posedge clock) begin
    if (rst) filterAdaptActive <= 1'h0;
    else     filterAdaptActive <= dynamicGo;
  end

  // Sweep start point: largest clock delay is the upper limit
  wire [3:0] sweepOrigin = midpointStart ? sfeac_pkg::FILTER_MIDPOINT : upperLimit;
  wire [3:0] stepUp   = (filterSetting == 4'hF) ? filterSetting : filterSetting + 4'h1;
  wire [3:0] stepDown = (filterSetting == 4'h0) ? filterSetting : filterSetting - 4'h1;

  logic [3:0] next_filterSetting;
  always_comb begin
    next_filterSetting = filterSetting;
    if (eqSweepStart)
      next_filterSetting = sweepOrigin;
    else if (dynamicGo && filterIncrement && !filterDecrement)
      next_filterSetting = stepUp;
    else if (dynamicGo && filterDecrement && !filterIncrement)
      next_filterSetting = stepDown;
  end

  // Clamping also pulls the setting back in after limits are reprogrammed
  always_ff @(posedge clock) begin
    if (rst) filterSetting <= sfeac_pkg::FILTER_MIDPOINT;
    else     filterSetting <= clampSetting(next_filterSetting, lowerLimit, upperLimit);
  end

  // Selected error strobe
  wire errHit = (errSelect[2] && linkErr.clockBit)
             || (errSelect[1] && linkErr.controlSequence)
             || (errSelect[0] && linkErr.parity);
  wire errCheckOn = |errSelect;

  // Accumulation window of half the relock period
  logic [CNT_W-1:0] winCount;
  logic [7:0]       errCount;
  wire winRun  = eqAdaptActive && errCheckOn;
  wire winLast = winRun && (winCount == HALF_LAST);
  wire [7:0] errCountInc = (errCount == 8'hFF) ? errCount : errCount + 8'h01;

  always_ff @(posedge clock) begin
    if (rst || !winRun || winLast) winCount <= '0;
    else                           winCount <= winCount + CNT_W'(1);
  end

  // A hit in the last cycle starts the next window's count
  always_ff @(posedge clock) begin
    if (rst || !winRun)  errCount <= 8'h00;
    else if (winLast)    errCount <= errHit ? 8'h01 : 8'h00;
    else if (errHit)     errCount <= errCountInc;
  end

  // Final cycle's hit counts toward the compare
  wire [7:0] finalCount = errHit ? errCountInc : errCount;

  always_ff @(posedge clock) begin
    if (rst) eqStepUp <= 1'h0;
    else     eqStepUp <= winLast && (finalCount > errThreshold);
  end

  // Two-step trial validation
  sfeac_pkg::sfeac_val_e valState;
  logic [CNT_W-1:0]      valCount;
  wire valHalfDone = (valCount == HALF_LAST);
  wire valErr      = errCheckOn && errHit;

  always_ff @(posedge clock) begin
    if (rst) begin
      valState     <= sfeac_pkg::VAL_IDLE;
      valCount     <= '0;
      trialVerdict <= '0;
    end else begin
      trialVerdict <= '0;
      case (valState)
        sfeac_pkg::VAL_IDLE: begin
          valCount <= '0;
          if (eqTrialStart && twoStepEn) valState <= sfeac_pkg::VAL_WAIT;
        end
        sfeac_pkg::VAL_WAIT: begin
          valCount <= valHalfDone ? '0 : valCount + CNT_W'(1);
          if (valHalfDone) valState <= sfeac_pkg::VAL_CHECK;
        end
        sfeac_pkg::VAL_CHECK: begin
          valCount <= valCount + CNT_W'(1);
          if (valErr) begin
            trialVerdict.fail <= 1'h1;
            valState          <= sfeac_pkg::VAL_IDLE;
          end else if (valHalfDone) begin
            trialVerdict.pass <= 1'h1;
            valState          <= sfeac_pkg::VAL_IDLE;
          end
        end
        default: valState <= sfeac_pkg::VAL_IDLE;
      endcase
    end
  end

endmodule

// *** dv/sfeac_remote_model.sv ***
// Remote serializer stand-in that puts error strobes on the forward link
module sfeac_remote_model (
  // Clock and error injection
  input  wire logic            clock,
  input  wire logic [2:0]      inject,
  // Error strobes toward the receiver
  output sfeac_pkg::sfeac_err_s linkErr
);
  timeunit 1ns;
  timeprecision 1ps;
  // A glitch lasts exactly one link cycle, so each injection is one strobe
  always_ff @(posedge clock) begin
    linkErr <= inject;
  end
endmodule

// *** dv/sfeac_ctrl_chk.sv ***
// Port assertions for the adaption control block
module sfeac_ctrl_chk #(
  parameter int RELOCK_CYCLES = 8192
) (
  // Watched ports
  input wire logic                      clock,
  input wire logic                      rst,
  input wire logic [7:0]                regAddr,
  input wire logic                      regRead,
  input wire logic [7:0]                regRdata,
  input wire sfeac_pkg::sfeac_err_s     linkErr,
  input wire logic                      eqTrialStart,
  input wire logic [3:0]                filterSetting,
  input wire logic                      eqStepUp,
  input wire sfeac_pkg::sfeac_verdict_s trialVerdict
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  a_setting_max: assert property (filterSetting <= 4'hE) else $error("filter above 14");
  a_reset_values: assert property (disable iff (1'b0) rst |=> filterSetting == 4'h7
    && !eqStepUp && trialVerdict == 2'h0) else $error("bad reset outputs");
  a_reserved_zero: assert property (regRead && regAddr == 8'h42 |=> !regRdata[7])
    else $error("reserved bit read as one");
  // Steps come from whole windows, so two can never be closer than half a period
  a_stepup_gap: assert property (eqStepUp |=> !eqStepUp [*3]) else $error("step too soon");
  a_verdict_excl: assert property (!(trialVerdict.pass && trialVerdict.fail))
    else $error("pass and fail together");
  a_verdict_quiet: assert property (trialVerdict != 2'h0 |=> trialVerdict == 2'h0)
    else $error("verdict longer than one cycle");
  a_pass_time: assert property (trialVerdict.pass |-> $past(eqTrialStart, RELOCK_CYCLES + 1))
    else $error("pass at wrong time");
  a_fail_cause: assert property (trialVerdict.fail |-> $past(linkErr) != 3'h0)
    else $error("fail without error");
endmodule

// *** dv/sfeac_ctrl_test.sv ***
// Self-checking bench for the adaption control block
module sfeac_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0, rst = 1'h1, regWrite = 1'h0, regRead = 1'h0, freqLock = 1'h0;
  logic eqAdaptDone = 1'h0, eqAdaptActive = 1'h0, filterIncrement = 1'h0, filterDecrement = 1'h0;
  logic eqSweepStart = 1'h0, eqTrialStart = 1'h0, filterAdaptActive, eqStepUp;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rd;
  logic [3:0] filterSetting;
  logic [2:0] inject = 3'h0;
  sfeac_pkg::sfeac_err_s linkErr;
  sfeac_pkg::sfeac_verdict_s trialVerdict;
  int n_mismatch = 0, n_checks = 0;
  always #2.5 clock = ~clock;
  sfeac_ctrl #(.RELOCK_CYCLES(8)) sfeac_ctrl_i (.clock, .rst, .regAddr, .regWrite, .regWdata, .regRead,
    .regRdata, .freqLock, .eqAdaptDone, .eqAdaptActive, .linkErr, .filterIncrement, .filterDecrement,
    .eqSweepStart, .eqTrialStart, .filterSetting, .filterAdaptActive, .eqStepUp, .trialVerdict);
  sfeac_remote_model sfeac_remote_model_i (.clock, .inject, .linkErr);
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    {regWrite, regRead} <= {w, !w};
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    {regWrite, regRead} <= 2'h0;
    #1 rd = regRdata;
  endtask
  task automatic regs;
    logic [7:0] rv [4] = '{8'h00, 8'h86, 8'h74, 8'h01};
    for (int i = 0; i < 4; i++) begin
      acc(1'h0, 8'h40 + 8'(i), 8'h00);
      check(rd, rv[i]);
    end
    acc(1'h1, 8'h42, 8'hFF);
    acc(1'h0, 8'h42, 8'h00);
    check(rd, 8'h7F);
  endtask
  // Write one register, then pulse sweep, increment or decrement and check the setting
  task automatic go(logic [7:0] a, logic [7:0] d, logic [2:0] p, logic [3:0] e);
    acc(1'h1, a, d);
    @(posedge clock);
    {eqSweepStart, filterIncrement, filterDecrement} <= p;
    @(posedge clock);
    {eqSweepStart, filterIncrement, filterDecrement} <= 3'h0;
    #1 check({4'h0, filterSetting}, {4'h0, e});
  endtask
  task automatic win(logic [2:0] sel, logic [2:0] e1, logic [2:0] e2, logic exp);
    logic seen = 1'h0;
    acc(1'h1, 8'h42, {1'h0, sel, 4'h0});
    @(posedge clock);
    eqAdaptActive <= 1'h1;
    inject <= e1;
    @(posedge clock);
    inject <= e2;
    @(posedge clock);
    inject <= 3'h0;
    repeat (8) begin
      @(posedge clock);
      seen |= eqStepUp;
    end
    eqAdaptActive <= 1'h0;
    repeat (2) @(posedge clock);
    check({7'h0, seen}, {7'h0, exp});
  endtask
  // Errors injected in the wait half must not spoil a trial
  task automatic trial(logic [7:0] ctl, int at, logic [1:0] exp);
    logic [1:0] seen = 2'h0;
    acc(1'h1, 8'h42, ctl);
    @(posedge clock);
    eqTrialStart <= 1'h1;
    @(posedge clock);
    eqTrialStart <= 1'h0;
    for (int i = 0; i < 12; i++) begin
      @(posedge clock);
      inject <= (i == at) ? 3'h7 : 3'h0;
      seen |= trialVerdict;
    end
    check({6'h0, seen}, {6'h0, exp});
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    regs();
    go(8'h40, 8'h00, 3'h2, 4'h7);
    check({7'h0, filterAdaptActive}, 8'h00);
    go(8'h40, 8'h01, 3'h2, 4'h7);
    check({7'h0, filterAdaptActive}, 8'h00);
    freqLock <= 1'h1;
    go(8'h40, 8'h01, 3'h2, 4'h8);
    check({7'h0, filterAdaptActive}, 8'h01);
    go(8'h40, 8'h01, 3'h2, 4'h8);
    go(8'h40, 8'h01, 3'h1, 4'h7);
    go(8'h40, 8'h01, 3'h1, 4'h6);
    go(8'h40, 8'h01, 3'h1, 4'h6);
    go(8'h40, 8'h03, 3'h2, 4'h6);
    check({7'h0, filterAdaptActive}, 8'h00);
    eqAdaptDone <= 1'h1;
    go(8'h40, 8'h03, 3'h2, 4'h7);
    freqLock <= 1'h0;
    go(8'h40, 8'h81, 3'h2, 4'h8);
    check({7'h0, filterAdaptActive}, 8'h01);
    go(8'h42, 8'h74, 3'h4, 4'h8);
    go(8'h42, 8'h7C, 3'h4, 4'h7);
    go(8'h41, 8'hF0, 3'h2, 4'h8);
    go(8'h42, 8'h74, 3'h4, 4'hE);
    go(8'h41, 8'hF0, 3'h2, 4'hE);
    acc(1'h1, 8'h41, 8'hB9);
    go(8'h42, 8'h7C, 3'h4, 4'h9);
    win(3'h7, 3'h1, 3'h0, 1'h0);
    win(3'h0, 3'h7, 3'h7, 1'h0);
    for (int b = 0; b < 3; b++) begin
      win(3'h1 << b, ~(3'h1 << b), ~(3'h1 << b), 1'h0);
      win(3'h1 << b, 3'h1 << b, 3'h1 << b, 1'h1);
    end
    // Raised threshold: two hits no longer exceed it
    acc(1'h1, 8'h43, 8'h02);
    win(3'h7, 3'h7, 3'h7, 1'h0);
    trial(8'h74, 99, 2'h2);
    trial(8'h74, 0, 2'h2);
    trial(8'h74, 3, 2'h1);
    trial(8'h70, 99, 2'h0);
    summarize();
  end
endmodule
bind sfeac_ctrl sfeac_ctrl_chk #(.RELOCK_CYCLES(RELOCK_CYCLES)) sfeac_ctrl_chk_i (.clock, .rst, .regAddr,
  .regRead, .regRdata, .linkErr, .eqTrialStart, .filterSetting, .eqStepUp, .trialVerdict);
